// file: lightbar_cfg_pkg.sv
// Shared constants and types for the light-bar configuration block
package lightbar_cfg_pkg;
  // Switch positions in the bank, bit set means switch down (ON)
  localparam int NUM_SW         = 8;
  localparam int SW_CUT_POL     = 0;
  localparam int SW_KEEP_UP     = 1;
  localparam int SW_LEAD_MAP    = 2;
  localparam int SW_DIRECTOR    = 3;
  localparam int SW_STEP_DIR    = 4;
  localparam int SW_PROG        = 5;
  localparam int SW_ISECT_TAP   = 6;
  localparam int SW_ISECT_TIMED = 7;

  // Pattern slots
  localparam int          NUM_SLOTS  = 4;
  localparam logic [1:0]  SLOT_M1    = 2'h0;
  localparam logic [1:0]  SLOT_M2    = 2'h1;
  localparam logic [1:0]  SLOT_M3    = 2'h2;
  localparam logic [1:0]  SLOT_ISECT = 2'h3;

  // Active mode codes
  localparam logic [1:0] MODE_NONE = 2'h0;
  localparam logic [1:0] MODE_1    = 2'h1;
  localparam logic [1:0] MODE_2    = 2'h2;
  localparam logic [1:0] MODE_3    = 2'h3;

  // Register map, byte addresses
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] ADDR_CTRL   = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_PAT0   = 12'h010;
  localparam logic [11:0] ADDR_PAT3   = 12'h01C;
  localparam int          CTRL_LOCK   = 0;
  localparam int          CTRL_STEP   = 1;
  localparam int          ST_PROGBIT  = 8;
  localparam int          ST_MODE_LO  = 9;
  localparam int          ST_BLANK    = 11;
  localparam int          ST_ISECT    = 12;
  localparam int          ST_READY    = 13;

  // Timing, figures in their own units
  localparam longint CLK_HZ        = 200_000_000;
  localparam longint ISECT_TIME_S  = 8;
  localparam longint BLANK_TIME_MS = 100;
  localparam longint DEBOUNCE_MS   = 10;
  localparam longint ISECT_CYC     = ISECT_TIME_S * CLK_HZ;
  localparam longint BLANK_CYC     = BLANK_TIME_MS * CLK_HZ / 1000;
  localparam longint DEBOUNCE_CYC  = DEBOUNCE_MS * CLK_HZ / 1000;

  typedef enum logic [2:0] {
    ISECT_HOLD  = 3'b001,
    ISECT_TAP   = 3'b010,
    ISECT_TIMED = 3'b100
  } isect_mode_e;

  typedef enum logic [2:0] {
    ST_CAPTURE = 3'b001,
    ST_RUN     = 3'b010,
    ST_PROGRAM = 3'b100
  } run_state_e;
endpackage : lightbar_cfg_pkg

// file: lightbar_ctl_if.sv
// Internal carrier between the top and its helper units
interface lightbar_ctl_if;
  logic                         press;
  logic                         isect_req;
  lightbar_cfg_pkg::isect_mode_e isect_sel;
  logic                         isect_active;

  modport debouncer (output press);
  modport isect (input isect_req, input isect_sel, output isect_active);
  modport top (input press, input isect_active, output isect_req, output isect_sel);
endinterface : lightbar_ctl_if

// file: step_button_filter.sv
// Debounce of the pattern-step button with a one-cycle press pulse
module step_button_filter #(
  parameter int unsigned DEB_CYC = 32'(lightbar_cfg_pkg::DEBOUNCE_CYC)
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Raw button
  input  wire logic button,
  // Filtered press
  lightbar_ctl_if.debouncer ctl
);
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic        stable;
  logic        next_stable;
  logic        pulse;
  logic        next_pulse;

  // Stable level only moves after the input has held for the full count
  always_comb begin
    next_cnt    = '0;
    next_stable = stable;
    next_pulse  = 1'b0;
    if (button != stable) begin
      next_cnt = cnt + 32'h1;
      if (cnt + 32'h1 >= DEB_CYC) begin
        next_cnt    = '0;
        next_stable = button;
        next_pulse  = button;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt    <= '0;
      stable <= 1'b0;
      pulse  <= 1'b0;
    end else begin
      cnt    <= next_cnt;
      stable <= next_stable;
      pulse  <= next_pulse;
    end
  end

  assign ctl.press = pulse;
endmodule : step_button_filter

// file: isect_unit.sv
// Intersection activation: maintained, toggle or timed
module isect_unit #(
  parameter int unsigned ISECT_CYC = 32'(lightbar_cfg_pkg::ISECT_CYC)
) (
  // Clock and reset
  input  wire logic pclk,
  input  wire logic presetn,
  // Request and result
  lightbar_ctl_if.isect ctl
);
  logic        req_d;
  logic        active;
  logic [31:0] timer;
  logic        next_active;
  logic [31:0] next_timer;

  always_comb begin
    next_active = active;
    next_timer  = '0;
    case (ctl.isect_sel)
      lightbar_cfg_pkg::ISECT_HOLD: begin
        next_active = ctl.isect_req;
      end
      lightbar_cfg_pkg::ISECT_TAP: begin
        if (ctl.isect_req && !req_d) begin
          next_active = !active;
        end
      end
      lightbar_cfg_pkg::ISECT_TIMED: begin
        // Retrigger while running restarts the full period
        if (ctl.isect_req && !req_d) begin
          next_active = 1'b1;
          next_timer  = ISECT_CYC - 32'h1;
        end else if (timer != '0) begin
          next_timer = timer - 32'h1;
        end else begin
          next_active = 1'b0;
        end
      end
      default: begin
        next_active = 1'b0;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      req_d  <= 1'b0;
      active <= 1'b0;
      timer  <= '0;
    end else begin
      req_d  <= ctl.isect_req;
      active <= next_active;
      timer  <= next_timer;
    end
  end

  assign ctl.isect_active = active;
endmodule : isect_unit

// file: lightbar_config.sv
// Configuration switch decode and flash-pattern programming for the light bar
// Function
// - Switch 1 up: high inputs cut front/rear heads; down: high inputs enable them.
// - Switch 3 up: lead A is intersection request, lead B is self-test.
// - Switch 3 down: lead A is left flood, lead B is right flood.
// - Switch 3 down disables intersection and self-test.
// - Flood outputs only act when the bar supports flood lighting.
// - Step press goes forward with switch 5 up, backward when down.
// - Pattern selection works only while switch 1 is off.
// - Each step blanks the bar briefly before the new pattern shows.
// - In program mode each press steps the active mode's pattern.
// - Switch 6 down at power-up gives program mode, else normal operation.
// - Mode 1 plus intersection high programs the intersection pattern.
// - Cruise light available while mode 1 or 2 is active.
// - Switch 4 down selects on-board directional controller, up external.
// - Switches 7/8 select maintained, toggle or 8-second timed intersection.
// - Mode 3 overrides mode 2, mode 2 overrides mode 1.
module lightbar_config #(
  parameter int          PAT_W     = 5,
  parameter logic [4:0]  NUM_PAT   = 5'h10,
  parameter int unsigned ISECT_CYC = 32'(lightbar_cfg_pkg::ISECT_CYC),
  parameter int unsigned BLANK_CYC = 32'(lightbar_cfg_pkg::BLANK_CYC),
  parameter int unsigned DEB_CYC   = 32'(lightbar_cfg_pkg::DEBOUNCE_CYC)
) (
  // Clock and reset
  input  wire logic                pclk,
  input  wire logic                presetn,
  // APB slave
  input  wire logic [11:0]         paddr,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Installer side
  input  wire logic [7:0]          config_switch_bank,
  input  wire logic                pattern_step_button,
  input  wire logic                store_clear,
  // Control leads
  input  wire logic [2:0]          mode_in,
  input  wire logic                front_cut_in,
  input  wire logic                rear_cut_in,
  input  wire logic                shared_lead_a,
  input  wire logic                shared_lead_b,
  input  wire logic                bar_has_flood,
  // Light bar side
  output logic                     front_enable,
  output logic                     rear_enable,
  output logic [1:0]               active_mode,
  output logic [PAT_W-1:0]         active_pattern,
  output logic                     bar_blank,
  output logic                     intersection_on,
  output logic                     self_test_on,
  output logic                     area_flood_light_left,
  output logic                     area_flood_light_right,
  output logic                     cruise_avail,
  output logic                     internal_director,
  output logic                     program_mode
);
  lightbar_ctl_if ctl ();

  // Highest active mode wins
  function automatic logic [1:0] top_mode(input logic [2:0] m);
    if (m[2]) return lightbar_cfg_pkg::MODE_3;
    if (m[1]) return lightbar_cfg_pkg::MODE_2;
    if (m[0]) return lightbar_cfg_pkg::MODE_1;
    return lightbar_cfg_pkg::MODE_NONE;
  endfunction : top_mode

  // Wrapping step through the pattern list
  function automatic logic [PAT_W-1:0] step_pat(input logic [PAT_W-1:0] p, input logic back);
    logic [PAT_W-1:0] last;
    last = PAT_W'(NUM_PAT - 5'h1);
    if (back) return (p == '0) ? last : p - PAT_W'(1);
    return (p >= last) ? '0 : p + PAT_W'(1);
  endfunction : step_pat

  step_button_filter #(.DEB_CYC(DEB_CYC)) u_btn (
    .pclk    (pclk),
    .presetn (presetn),
    .button  (pattern_step_button),
    .ctl     (ctl.debouncer)
  );

  isect_unit #(.ISECT_CYC(ISECT_CYC)) u_isect (
    .pclk    (pclk),
    .presetn (presetn),
    .ctl     (ctl.isect)
  );

  // Strap capture and run state
  lightbar_cfg_pkg::run_state_e state;
  lightbar_cfg_pkg::run_state_e next_state;
  logic [7:0] sw;
  logic [7:0] next_sw;

  // Switches are taken once after power-up; later moves wait for the next cycle of power
  always_comb begin
    next_state = state;
    next_sw    = sw;
    case (state)
      lightbar_cfg_pkg::ST_CAPTURE: begin
        next_sw = config_switch_bank;
        if (config_switch_bank[lightbar_cfg_pkg::SW_PROG]) begin
          next_state = lightbar_cfg_pkg::ST_PROGRAM;
        end else begin
          next_state = lightbar_cfg_pkg::ST_RUN;
        end
      end
      lightbar_cfg_pkg::ST_RUN:     next_state = lightbar_cfg_pkg::ST_RUN;
      lightbar_cfg_pkg::ST_PROGRAM: next_state = lightbar_cfg_pkg::ST_PROGRAM;
      default:                      next_state = lightbar_cfg_pkg::ST_CAPTURE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= lightbar_cfg_pkg::ST_CAPTURE;
      sw    <= '0;
    end else begin
      state <= next_state;
      sw    <= next_sw;
    end
  end

  // Decode of leads and switches
  logic       in_prog;
  logic       in_run;
  logic       lead_isect;
  logic [1:0] hi_mode;
  logic       any_mode;
  logic [1:0] slot;

  assign in_prog    = (state == lightbar_cfg_pkg::ST_PROGRAM);
  assign in_run     = (state == lightbar_cfg_pkg::ST_RUN);
  assign hi_mode    = top_mode(mode_in);
  assign any_mode   = (hi_mode != lightbar_cfg_pkg::MODE_NONE);
  assign lead_isect = shared_lead_a && !sw[lightbar_cfg_pkg::SW_LEAD_MAP];

  always_comb begin
    slot = hi_mode - 2'h1;
    if (in_prog && mode_in[0] && lead_isect) begin
      slot = lightbar_cfg_pkg::SLOT_ISECT;
    end else if (in_run && ctl.isect_active) begin
      slot = lightbar_cfg_pkg::SLOT_ISECT;
    end
  end

  assign ctl.isect_req = in_run && lead_isect && any_mode;
  assign ctl.isect_sel = sw[lightbar_cfg_pkg::SW_ISECT_TAP]   ? lightbar_cfg_pkg::ISECT_TAP :
                         sw[lightbar_cfg_pkg::SW_ISECT_TIMED] ? lightbar_cfg_pkg::ISECT_TIMED :
                         lightbar_cfg_pkg::ISECT_HOLD;

  // APB slave, zero wait states
  logic        lock;
  logic        next_lock;
  logic        soft_step;
  logic        next_soft_step;
  logic [31:0] next_prdata;
  logic        next_pready;
  logic        next_pslverr;
  logic        wr_en;
  logic        pat_hit;
  logic [1:0]  pat_idx;

  assign wr_en   = psel && penable && pwrite && pready;
  assign pat_hit = (paddr >= lightbar_cfg_pkg::ADDR_PAT0) && (paddr <= lightbar_cfg_pkg::ADDR_PAT3)
                   && (paddr[1:0] == 2'h0);
  assign pat_idx = paddr[3:2];

  logic [PAT_W-1:0] pat_mem [lightbar_cfg_pkg::NUM_SLOTS];

  always_comb begin
    next_lock      = lock;
    next_soft_step = 1'b0;
    next_prdata    = '0;
    next_pready    = 1'b0;
    next_pslverr   = 1'b0;
    if (psel && !penable) begin
      next_pready = 1'b1;
      if (paddr == lightbar_cfg_pkg::ADDR_CTRL) begin
        next_prdata[lightbar_cfg_pkg::CTRL_LOCK] = lock;
      end else if (paddr == lightbar_cfg_pkg::ADDR_STATUS) begin
        next_prdata[7:0] = sw;
        next_prdata[lightbar_cfg_pkg::ST_PROGBIT] = in_prog;
        next_prdata[lightbar_cfg_pkg::ST_MODE_LO +: 2] = active_mode;
        next_prdata[lightbar_cfg_pkg::ST_BLANK] = bar_blank;
        next_prdata[lightbar_cfg_pkg::ST_ISECT] = intersection_on;
        next_prdata[lightbar_cfg_pkg::ST_READY] = (state != lightbar_cfg_pkg::ST_CAPTURE);
      end else if (pat_hit) begin
        next_prdata[PAT_W-1:0] = pat_mem[pat_idx];
      end else begin
        next_pslverr = 1'b1;
      end
    end
    if (wr_en && paddr == lightbar_cfg_pkg::ADDR_CTRL) begin
      next_lock      = pwdata[lightbar_cfg_pkg::CTRL_LOCK];
      next_soft_step = pwdata[lightbar_cfg_pkg::CTRL_STEP];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock      <= 1'b0;
      soft_step <= 1'b0;
      prdata    <= '0;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      lock      <= next_lock;
      soft_step <= next_soft_step;
      prdata    <= next_prdata;
      pready    <= next_pready;
      pslverr   <= next_pslverr;
    end
  end

  // Pattern stepping and blanking
  logic        step_go;
  logic [31:0] blank_cnt;
  logic [31:0] next_blank_cnt;

  assign step_go = (ctl.press || soft_step) && in_prog && !lock && any_mode
                   && !sw[lightbar_cfg_pkg::SW_CUT_POL];

  always_comb begin
    next_blank_cnt = (blank_cnt != '0) ? blank_cnt - 32'h1 : '0;
    if (step_go) begin
      next_blank_cnt = BLANK_CYC;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blank_cnt <= '0;
    end else begin
      blank_cnt <= next_blank_cnt;
    end
  end

  // No reset here: the store models non-volatile cells across power cycles
  always_ff @(posedge pclk) begin
    for (int i = 0; i < lightbar_cfg_pkg::NUM_SLOTS; i++) begin
      if (store_clear) begin
        pat_mem[i] <= '0;
      end else if (step_go && slot == 2'(i)) begin
        pat_mem[i] <= step_pat(pat_mem[i], sw[lightbar_cfg_pkg::SW_STEP_DIR]);
      end else if (wr_en && pat_hit && pat_idx == 2'(i)) begin
        pat_mem[i] <= pwdata[PAT_W-1:0];
      end
    end
  end

  // Registered outputs to the light bar
  logic             cut_hi;
  logic             ready;
  logic             flood_ok;
  logic             next_front;
  logic             next_rear;
  logic [1:0]       next_mode;
  logic [PAT_W-1:0] next_pat;
  logic             next_blank;
  logic             next_isect;
  logic             next_test;
  logic             next_fl;
  logic             next_fr;
  logic             next_cruise;
  logic             next_dir;
  logic             next_prog;

  assign ready    = (state != lightbar_cfg_pkg::ST_CAPTURE);
  assign cut_hi   = !sw[lightbar_cfg_pkg::SW_CUT_POL];
  assign flood_ok = ready && sw[lightbar_cfg_pkg::SW_LEAD_MAP] && bar_has_flood;

  always_comb begin
    next_front  = ready && (cut_hi ? !front_cut_in : front_cut_in);
    next_rear   = ready && (cut_hi ? !rear_cut_in : rear_cut_in);
    next_mode   = ready ? hi_mode : lightbar_cfg_pkg::MODE_NONE;
    next_pat    = (ready && any_mode) ? pat_mem[slot] : '0;
    next_blank  = (blank_cnt != '0) || step_go;
    next_isect  = in_run && ctl.isect_active;
    next_test   = in_run && shared_lead_b && !sw[lightbar_cfg_pkg::SW_LEAD_MAP];
    next_fl     = flood_ok && shared_lead_a;
    next_fr     = flood_ok && shared_lead_b;
    next_cruise = ready && (hi_mode == lightbar_cfg_pkg::MODE_1 || hi_mode == lightbar_cfg_pkg::MODE_2);
    next_dir    = ready && sw[lightbar_cfg_pkg::SW_DIRECTOR];
    next_prog   = in_prog;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      front_enable           <= 1'b0;
      rear_enable            <= 1'b0;
      active_mode            <= lightbar_cfg_pkg::MODE_NONE;
      active_pattern         <= '0;
      bar_blank              <= 1'b0;
      intersection_on        <= 1'b0;
      self_test_on           <= 1'b0;
      area_flood_light_left  <= 1'b0;
      area_flood_light_right <= 1'b0;
      cruise_avail           <= 1'b0;
      internal_director      <= 1'b0;
      program_mode           <= 1'b0;
    end else begin
      front_enable           <= next_front;
      rear_enable            <= next_rear;
      active_mode            <= next_mode;
      active_pattern         <= next_pat;
      bar_blank              <= next_blank;
      intersection_on        <= next_isect;
      self_test_on           <= next_test;
      area_flood_light_left  <= next_fl;
      area_flood_light_right <= next_fr;
      cruise_avail           <= next_cruise;
      internal_director      <= next_dir;
      program_mode           <= next_prog;
    end
  end
endmodule : lightbar_config

// file: lightbar_notes_placeholder_removed.sv
// Spare compile unit, holds nothing

// file: lightbar_config_props.sv
// Checker for switch decode and pattern stepping of lightbar_config
module lightbar_config_props (
  // Clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // APB
  input wire logic       psel,
  input wire logic       penable,
  input wire logic       pready,
  input wire logic       pslverr,
  // Installer and leads
  input wire logic [7:0] config_switch_bank,
  input wire logic [2:0] mode_in,
  input wire logic       front_cut_in,
  input wire logic       rear_cut_in,
  input wire logic       shared_lead_a,
  input wire logic       shared_lead_b,
  input wire logic       bar_has_flood,
  // Light bar side
  input wire logic       front_enable,
  input wire logic       rear_enable,
  input wire logic [1:0] active_mode,
  input wire logic       bar_blank,
  input wire logic       intersection_on,
  input wire logic       self_test_on,
  input wire logic       area_flood_light_left,
  input wire logic       area_flood_light_right,
  input wire logic       cruise_avail,
  input wire logic       internal_director,
  input wire logic       program_mode
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Edges since reset; outputs settle on the second
  logic [1:0] up;
  logic       rdy;
  assign rdy = up == 2'h3;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      up <= 2'h0;
    else if (up != 2'h3)
      up <= up + 2'h1;
  end
  wire logic [7:0] sw = config_switch_bank;
  property p_cut;
    rdy && $stable(front_cut_in) && $stable(rear_cut_in) |->
      front_enable == !(sw[0] ^ front_cut_in) && rear_enable == !(sw[0] ^ rear_cut_in);
  endproperty
  a_cut: assert property (p_cut) else $error("head enable polarity wrong");
  property p_lead_test;
    rdy && !sw[2] && !program_mode && $stable(shared_lead_b) |-> self_test_on == shared_lead_b;
  endproperty
  a_lead_test: assert property (p_lead_test) else $error("self test lead wrong");
  property p_no_isect;
    rdy && sw[2] |-> !intersection_on && !self_test_on;
  endproperty
  a_no_isect: assert property (p_no_isect) else $error("intersection with flood map");
  property p_flood;
    rdy && sw[2] && bar_has_flood && $stable(bar_has_flood) && $stable(shared_lead_a) && $stable(shared_lead_b)
      |-> area_flood_light_left == shared_lead_a && area_flood_light_right == shared_lead_b;
  endproperty
  a_flood: assert property (p_flood) else $error("flood lead map wrong");
  property p_flood_off;
    rdy && !bar_has_flood && $past(bar_has_flood) == 1'h0 |-> !area_flood_light_left && !area_flood_light_right;
  endproperty
  a_flood_off: assert property (p_flood_off) else $error("flood on unsupported bar");
  property p_director;
    rdy |-> internal_director == sw[3];
  endproperty
  a_director: assert property (p_director) else $error("director source wrong");
  property p_prog;
    rdy |-> program_mode == sw[5];
  endproperty
  a_prog: assert property (p_prog) else $error("program mode wrong");
  property p_cruise;
    rdy && $stable(mode_in) |-> cruise_avail == (!mode_in[2] && mode_in[1:0] != 2'h0);
  endproperty
  a_cruise: assert property (p_cruise) else $error("cruise availability wrong");
  property p_prio;
    rdy && $stable(mode_in) |->
      active_mode == (mode_in[2] ? 2'h3 : mode_in[1] ? 2'h2 : mode_in[0] ? 2'h1 : 2'h0);
  endproperty
  a_prio: assert property (p_prio) else $error("mode priority wrong");
  property p_blank;
    $rose(bar_blank) |-> bar_blank [*8];
  endproperty
  a_blank: assert property (p_blank) else $error("blank too short");
  property p_sel_lock;
    rdy && sw[0] |-> !bar_blank;
  endproperty
  a_sel_lock: assert property (p_sel_lock) else $error("step with switch 1 on");
  property p_apb;
    psel && !penable |=> pready;
  endproperty
  a_apb: assert property (p_apb) else $error("no access answer");
  c_step: cover property (rdy && $rose(bar_blank));
  c_isect: cover property (rdy && intersection_on);
  c_err: cover property (pready && pslverr);
endmodule : lightbar_config_props

bind lightbar_config lightbar_config_props props (.*);

// file: installer_model.sv
// Installer model: switch bank and a chattering step button
module installer_model #(
  parameter int HOLD = 8
) (
  // Clock
  input  wire logic       pclk,
  // Bench requests
  input  wire logic [7:0] sw_want,
  input  wire logic       press_go,
  // Toward the block
  output logic      [7:0] config_switch_bank = 8'h00,
  output logic            pattern_step_button = 1'h0,
  output logic            press_busy
);
  timeunit 1ns;
  timeprecision 100ps;
  int cnt = 0;
  assign press_busy = press_go || cnt != 0;
  // One bounce after first contact, like a real contact
  always @(posedge pclk) begin
    config_switch_bank <= {sw_want[7:2], 1'h0, sw_want[0]};
    pattern_step_button <= cnt > HOLD && cnt != 2 * HOLD - 1;
    if (cnt != 0)
      cnt <= cnt - 1;
    else if (press_go)
      cnt <= 2 * HOLD;
  end
endmodule : installer_model

// file: lightbar_config_tb.sv
// Self-checking bench for lightbar_config
module lightbar_config_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, err, pready, pslverr;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [7:0]  sw_want = 8'h00, config_switch_bank;
  logic        press_go = 1'h0, press_busy, pattern_step_button, store_clear = 1'h0, saw_blank = 1'h0;
  logic [2:0]  mode_in = 3'h0;
  logic        front_cut_in = 1'h0, rear_cut_in = 1'h0, shared_lead_a = 1'h0, shared_lead_b = 1'h0;
  logic        bar_has_flood = 1'h0, front_enable, rear_enable, bar_blank, intersection_on, self_test_on;
  logic        area_flood_light_left, area_flood_light_right, cruise_avail, internal_director, program_mode;
  logic [1:0]  active_mode;
  logic [4:0]  active_pattern;
  int          failures = 0, checks_done = 0, cycles = 0;

  lightbar_config #(.ISECT_CYC(20), .BLANK_CYC(8), .DEB_CYC(4)) dut (.*);
  installer_model #(.HOLD(8)) partner (.*);

  initial begin
    forever #2.5 pclk = ~pclk;
  end

  // Blank watch and hang guard
  always @(posedge pclk) begin
    cycles++;
    if (bar_blank === 1'h1)
      saw_blank = 1'h1;
    if (cycles == 5000) begin
      failures++;
      tally_and_finish();
    end
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'h1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    while (pready !== 1'h1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb

  // Switches only change with power off
  task automatic power(input logic [7:0] s);
    presetn <= 1'h0;
    sw_want <= s;
    mode_in <= 3'h0;
    shared_lead_a <= 1'h0;
    shared_lead_b <= 1'h0;
    repeat (3) @(posedge pclk);
    presetn <= 1'h1;
    repeat (3) @(posedge pclk);
  endtask : power

  task automatic press(input int k, input logic blank_exp);
    repeat (k) begin
      saw_blank = 1'h0;
      press_go <= 1'h1;
      @(posedge pclk);
      press_go <= 1'h0;
      while (press_busy !== 1'h0)
        @(posedge pclk);
      repeat (12) @(posedge pclk);
      check(saw_blank, blank_exp);
    end
  endtask : press

  task automatic t_program;
    logic [31:0] exp [4];
    exp = '{32'h1, 32'h2, 32'h3, 32'h2};
    power(8'h20);
    store_clear <= 1'h1;
    @(posedge pclk);
    store_clear <= 1'h0;
    apb(1'h0, lightbar_cfg_pkg::ADDR_STATUS, 32'h0);
    check(rd[13:0], 14'h2120);
    apb(1'h0, 12'h100, 32'h0);
    check(err, 1'h1);
    check(rd, 32'h0);
    press(1, 1'h0);
    mode_in <= 3'h4;
    press(3, 1'h1);
    check(active_pattern, 5'h03);
    mode_in <= 3'h2;
    press(2, 1'h1);
    mode_in <= 3'h1;
    press(1, 1'h1);
    shared_lead_a <= 1'h1;
    press(2, 1'h1);
    for (int i = 0; i < 4; i++) begin
      apb(1'h0, lightbar_cfg_pkg::ADDR_PAT0 + 12'(4 * i), 32'h0);
      check(rd, exp[i]);
    end
    $display("program test done");
  endtask : t_program

  task automatic t_backward;
    power(8'h30);
    mode_in <= 3'h1;
    press(2, 1'h1);
    check(active_pattern, 5'h0F);
    apb(1'h1, lightbar_cfg_pkg::ADDR_CTRL, 32'h2);
    repeat (14) @(posedge pclk);
    check(active_pattern, 5'h0E);
    apb(1'h1, lightbar_cfg_pkg::ADDR_CTRL, 32'h1);
    apb(1'h0, lightbar_cfg_pkg::ADDR_CTRL, 32'h0);
    check(rd[0], 1'h1);
    press(1, 1'h0);
    apb(1'h1, lightbar_cfg_pkg::ADDR_CTRL, 32'h0);
    $display("backward test done");
  endtask : t_backward

  task automatic t_blocked;
    power(8'h21);
    mode_in <= 3'h1;
    front_cut_in <= 1'h1;
    rear_cut_in <= 1'h0;
    press(1, 1'h0);
    check({front_enable, rear_enable, active_pattern}, {2'h2, 5'h0E});
    $display("blocked test done");
  endtask : t_blocked

  task automatic t_run;
    power(8'h08);
    shared_lead_b <= 1'h1;
    mode_in <= 3'h7;
    repeat (4) @(posedge pclk);
    check({internal_director, program_mode, self_test_on, front_enable, rear_enable}, 5'h15);
    check({active_mode, active_pattern, cruise_avail}, {2'h3, 5'h03, 1'h0});
    mode_in <= 3'h3;
    repeat (4) @(posedge pclk);
    check({active_mode, active_pattern, cruise_avail}, {2'h2, 5'h02, 1'h1});
    mode_in <= 3'h1;
    repeat (4) @(posedge pclk);
    check({active_pattern, cruise_avail}, {5'h0E, 1'h1});
    $display("run test done");
  endtask : t_run

  task automatic t_flood;
    power(8'h04);
    mode_in <= 3'h1;
    shared_lead_a <= 1'h1;
    shared_lead_b <= 1'h1;
    bar_has_flood <= 1'h1;
    repeat (5) @(posedge pclk);
    check({area_flood_light_left, area_flood_light_right, intersection_on, self_test_on}, 4'hC);
    bar_has_flood <= 1'h0;
    repeat (4) @(posedge pclk);
    check({area_flood_light_left, area_flood_light_right}, 2'h0);
    $display("flood test done");
  endtask : t_flood

  task automatic t_isect;
    logic [7:0] cfg [3];
    cfg = '{8'h00, 8'h40, 8'h80};
    for (int i = 0; i < 3; i++) begin
      power(cfg[i]);
      mode_in <= 3'h1;
      shared_lead_a <= 1'h1;
      repeat (6) @(posedge pclk);
      check(intersection_on, 1'h1);
      shared_lead_a <= 1'h0;
      repeat (6) @(posedge pclk);
      check(intersection_on, i != 0);
      repeat (30) @(posedge pclk);
      check(intersection_on, i == 1);
    end
    $display("intersection test done");
  endtask : t_isect

  task automatic tally_and_finish;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : tally_and_finish

  // Patterns first, cut-off polarity afterwards
  initial begin
    t_program();
    t_backward();
    t_blocked();
    t_run();
    t_flood();
    t_isect();
    tally_and_finish();
  end
endmodule : lightbar_config_tb
